// file: rtl/riw_ctrl.sv
// reset sequencing, pin states at reset and wake-up from the idle modes
`timescale 1ns/1ps
`default_nettype none

module riw_ctrl
  import riw_pkg::*;
#(
  parameter int N_PERIPH = riw_pkg::N_PERIPH_DEF,
  parameter int N_MUX = 6
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic rtc_por_n,
  input wire logic rtc_loss_clear,
  input wire logic cpu_soft_reset,
  input wire logic [N_PERIPH-1:0] periph_reset_req,
  input wire logic idle_enter,
  input wire logic idle_deep_sel,
  input wire logic clock_source_select,
  input wire logic ref_clk_tick,
  input wire logic rtc_clk_tick,
  input wire logic wake_input_pin,
  input wire logic [riw_pkg::N_EXT_INT-1:0] external_interrupt_pin,
  input wire logic rtc_interrupt,
  input wire logic [N_PERIPH-1:0] periph_int,
  input wire logic [N_PERIPH-1:0] periph_int_enable,
  input wire logic flag_request,
  input wire riw_pkg::riw_pin_req_t pin_req,
  input wire logic [N_MUX-1:0] external_bus_pin_select,
  input wire logic [N_MUX-1:0] mux_src_a,
  input wire logic [N_MUX-1:0] mux_src_b,
  output riw_pkg::riw_pins_t pins,
  output logic [N_MUX-1:0] mux_pin_out,
  output logic clock_gen_enable,
  output logic system_clock_bypass,
  output logic clk_src_ref,
  output logic boot_start,
  output logic cpu_active,
  output logic cpu_reset_n,
  output logic [N_PERIPH-1:0] periph_reset_n,
  output logic [N_PERIPH-1:0] int_pending,
  output logic wake_event,
  output logic rtc_power_loss_flag
);
  import riw_pkg::*;

  if (N_PERIPH < 1 || N_MUX < 1) begin : g_param_check
    $error("riw_ctrl: N_PERIPH and N_MUX must be at least 1");
  end

  // ==========================================================
  // synchronisers
  localparam int SYNC_W = 3 + N_EXT_INT + N_PERIPH;

  logic rst_sync;
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic wake_s;
  logic rtc_int_s;
  logic idle_deep_s;
  logic [N_EXT_INT-1:0] ext_int_s;
  logic [N_PERIPH-1:0] periph_int_s;
  logic wake_q;
  logic [N_EXT_INT-1:0] ext_int_q;
  logic rtc_int_q;

  // release of reset is seen a full two edges late, assertion at once
  riw_sync2 #(.WIDTH(1), .RESET_VALUE(1'b0)) u_rst_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d(1'b1),
    .q(rst_sync)
  );

  assign sync_in = {idle_deep_sel, wake_input_pin, rtc_interrupt, external_interrupt_pin,
                    periph_int};

  riw_sync2 #(.WIDTH(SYNC_W), .RESET_VALUE('0)) u_in_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d(sync_in),
    .q(sync_out)
  );

  assign periph_int_s = sync_out[N_PERIPH-1:0];
  assign ext_int_s = sync_out[N_PERIPH +: N_EXT_INT];
  assign rtc_int_s = sync_out[N_PERIPH + N_EXT_INT];
  assign wake_s = sync_out[N_PERIPH + N_EXT_INT + 1];
  assign idle_deep_s = sync_out[N_PERIPH + N_EXT_INT + 2];

  // ==========================================================
  // wake sources
  riw_state_t state;
  riw_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic woke_from_deep;

  logic wake_rise;
  logic ext_rise;
  logic rtc_rise;
  logic [N_PERIPH-1:0] masked_int;
  logic in_light;
  logic in_deep;
  logic light_wake;
  logic deep_wake;
  logic src_tick;
  logic ref_selected;

  assign wake_rise = wake_s & ~wake_q;
  assign ext_rise = |(ext_int_s & ~ext_int_q);
  assign rtc_rise = rtc_int_s & ~rtc_int_q;
  assign masked_int = periph_int_s & periph_int_enable;
  assign in_light = (state == ST_IDLE_LIGHT);
  assign in_deep = (state == ST_IDLE_DEEP);
  // external pins count as wake only while idle; while the cpu is active their edges are ignored
  assign light_wake = in_light & (ext_rise | rtc_rise | (|masked_int));
  assign deep_wake = in_deep & (ext_rise | rtc_rise | wake_rise);
  assign ref_selected = clock_source_select;
  assign src_tick = ref_selected ? ref_clk_tick : rtc_clk_tick;

  // ==========================================================
  // sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ST_RESET: begin
        if (rst_sync) begin
          next_state = ST_CLKGEN;
        end
      end
      ST_CLKGEN: next_state = ST_BOOT;
      ST_BOOT: next_state = ST_ACTIVE;
      ST_ACTIVE: begin
        if (cpu_soft_reset) begin
          next_state = ST_SOFT_RESET;
          next_cnt = '0;
        end else if (idle_enter) begin
          next_state = idle_deep_s ? ST_IDLE_DEEP : ST_IDLE_LIGHT;
        end
      end
      ST_IDLE_LIGHT: begin
        if (light_wake) begin
          next_state = ST_WAKE;
          next_cnt = '0;
        end
      end
      ST_IDLE_DEEP: begin
        if (deep_wake) begin
          next_state = ST_WAKE;
          next_cnt = '0;
        end
      end
      ST_WAKE: begin
        // the second tick after the event guarantees a full source period
        if (woke_from_deep) begin
          if (src_tick) begin
            next_cnt = cnt + 1'b1;
            if (cnt == DEEP_WAKE_LAST) begin
              next_state = ST_ACTIVE;
            end
          end
        end else begin
          next_cnt = cnt + 1'b1;
          if (cnt == LIGHT_WAKE_LAST) begin
            next_state = ST_ACTIVE;
          end
        end
      end
      ST_SOFT_RESET: begin
        next_cnt = cnt + 1'b1;
        if (cnt == SOFT_RESET_LAST) begin
          next_state = ST_BOOT;
        end
      end
      default: next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= ST_RESET;
      cnt <= '0;
      woke_from_deep <= 1'b0;
      wake_q <= 1'b0;
      ext_int_q <= '0;
      rtc_int_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wake_q <= wake_s;
      ext_int_q <= ext_int_s;
      rtc_int_q <= rtc_int_s;
      if (in_light || in_deep) begin
        woke_from_deep <= in_deep;
      end
    end
  end

  // ==========================================================
  // control outputs
  logic running;
  logic next_running;
  logic next_cpu_held;
  assign running = (state != ST_RESET);
  assign next_running = (next_state != ST_RESET);
  // cpu stays in reset while the generator starts, so it never runs unclocked
  assign next_cpu_held = (next_state == ST_RESET) || (next_state == ST_CLKGEN) ||
                         (next_state == ST_SOFT_RESET);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clock_gen_enable <= 1'b0;
      system_clock_bypass <= 1'b0;
      clk_src_ref <= 1'b0;
      boot_start <= 1'b0;
      cpu_active <= 1'b0;
      cpu_reset_n <= 1'b0;
      periph_reset_n <= '0;
      int_pending <= '0;
      wake_event <= 1'b0;
    end else begin
      clock_gen_enable <= next_running && (next_state != ST_IDLE_DEEP);
      system_clock_bypass <= (next_state == ST_IDLE_DEEP);
      clk_src_ref <= ref_selected;
      boot_start <= (next_state == ST_BOOT) && (state != ST_BOOT);
      cpu_active <= (next_state == ST_ACTIVE);
      cpu_reset_n <= !next_cpu_held;
      periph_reset_n <= running ? ~periph_reset_req : '0;
      int_pending <= masked_int;
      wake_event <= light_wake | deep_wake;
    end
  end

  // ==========================================================
  // pin states
  riw_pins_t next_pins;
  logic [N_MUX-1:0] next_mux;

  assign next_pins = running ? '{
    chip_select_n: pin_req.chip_select_n,
    byte_mask_n: pin_req.byte_mask_n,
    output_enable_n: pin_req.output_enable_n,
    write_enable_n: pin_req.write_enable_n,
    flag_output_pin: flag_request,
    serial_clk: pin_req.serial_clk,
    card_clk: pin_req.card_clk,
    data_oe_n: pin_req.data_oe_n,
    mem_addr: pin_req.mem_addr,
    mem_bank: pin_req.mem_bank
  } : PINS_AT_RESET;
  // muxed pins driven low in reset; select bit high picks source b
  assign next_mux = running ? ((mux_src_b & external_bus_pin_select) |
                               (mux_src_a & ~external_bus_pin_select)) : '0;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pins <= PINS_AT_RESET;
      mux_pin_out <= '0;
    end else begin
      pins <= next_pins;
      mux_pin_out <= next_mux;
    end
  end

  // ==========================================================
  // rtc domain flag
  // only the rtc supply monitor sets it; hardware reset leaves it alone
  always_ff @(posedge clk_sys or negedge rtc_por_n) begin
    if (!rtc_por_n) begin
      rtc_power_loss_flag <= RTC_LOSS_RESET;
    end else if (rtc_loss_clear) begin
      rtc_power_loss_flag <= ~RTC_LOSS_RESET;
    end
  end

endmodule : riw_ctrl

`default_nettype wire

// file: rtl/riw_pkg.sv
// shared constants and types of the reset and idle wake-up controller
package riw_pkg;

  // ==========================================================
  // timing
  localparam int SYS_CLK_MHZ = 50;
  localparam int SYS_CLK_PERIOD_NS = 1000 / SYS_CLK_MHZ;
  localparam int RESET_MIN_PERIODS = 3;
  localparam int LIGHT_WAKE_PERIODS = 3;
  localparam int DEEP_WAKE_TICKS = 2;
  localparam int SOFT_RESET_PERIODS = 3;
  localparam int CNT_W = 2;
  localparam logic [CNT_W-1:0] LIGHT_WAKE_LAST = CNT_W'(LIGHT_WAKE_PERIODS - 1);
  localparam logic [CNT_W-1:0] DEEP_WAKE_LAST = CNT_W'(DEEP_WAKE_TICKS - 1);
  localparam logic [CNT_W-1:0] SOFT_RESET_LAST = CNT_W'(SOFT_RESET_PERIODS - 1);

  // ==========================================================
  // widths and reset values
  localparam int N_EXT_INT = 2;
  localparam int N_PERIPH_DEF = 8;
  localparam int ADDR_W = 21;
  localparam int BANK_W = 2;
  localparam int DATA_W = 16;
  localparam int N_CS = 4;
  localparam logic RTC_LOSS_RESET = 1'b1;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_RESET,
    ST_CLKGEN,
    ST_BOOT,
    ST_ACTIVE,
    ST_IDLE_LIGHT,
    ST_IDLE_DEEP,
    ST_WAKE,
    ST_SOFT_RESET
  } riw_state_t;

  // levels of the memory and serial pins that this block owns
  typedef struct packed {
    logic [N_CS-1:0] chip_select_n;
    logic [1:0] byte_mask_n;
    logic output_enable_n;
    logic write_enable_n;
    logic flag_output_pin;
    logic serial_clk;
    logic card_clk;
    logic data_oe_n;
    logic [ADDR_W-1:0] mem_addr;
    logic [BANK_W-1:0] mem_bank;
  } riw_pins_t;

  // what the running memory and serial logic asks for outside reset
  typedef struct packed {
    logic [N_CS-1:0] chip_select_n;
    logic [1:0] byte_mask_n;
    logic output_enable_n;
    logic write_enable_n;
    logic serial_clk;
    logic card_clk;
    logic data_oe_n;
    logic [ADDR_W-1:0] mem_addr;
    logic [BANK_W-1:0] mem_bank;
  } riw_pin_req_t;

  localparam riw_pins_t PINS_AT_RESET = '{
    chip_select_n: '1,
    byte_mask_n: '1,
    output_enable_n: 1'b1,
    write_enable_n: 1'b1,
    flag_output_pin: 1'b1,
    serial_clk: 1'b0,
    card_clk: 1'b0,
    data_oe_n: 1'b1,
    mem_addr: '0,
    mem_bank: '1
  };

endpackage : riw_pkg

// file: rtl/riw_sync2.sv
// two-stage level synchroniser with a constant reset value
`timescale 1ns/1ps
`default_nettype none

module riw_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;

  // stage1 feeds only the second stage, never any other logic
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stage1 <= RESET_VALUE;
      q <= RESET_VALUE;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule : riw_sync2

`default_nettype wire

// file: testbench/riw_ctrl_properties.sv
// concurrent port checks of the reset and idle wake-up controller
`timescale 1ns/1ps
`default_nettype none
module riw_ctrl_chk
  import riw_pkg::*;
#(
  parameter int N_MUX = 6
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic rtc_por_n,
  input wire logic rtc_loss_clear,
  input wire logic cpu_soft_reset,
  input wire logic [N_MUX-1:0] external_bus_pin_select,
  input wire logic [N_MUX-1:0] mux_src_a,
  input wire logic [N_MUX-1:0] mux_src_b,
  input wire riw_pkg::riw_pins_t pins,
  input wire logic [N_MUX-1:0] mux_pin_out,
  input wire logic clock_gen_enable,
  input wire logic system_clock_bypass,
  input wire logic boot_start,
  input wire logic cpu_active,
  input wire logic cpu_reset_n,
  input wire logic wake_event,
  input wire logic rtc_power_loss_flag
);
  default clocking cb @(posedge clk_sys);
  endclocking

  // ==========
  // boot and soft reset steps
  sequence s_boot;
    boot_start && cpu_reset_n ##1 cpu_active && !boot_start;
  endsequence
  sequence s_soft;
    !cpu_reset_n [*3] ##1 s_boot;
  endsequence

  // ==========
  // assertions
  AST_PINS_RST: assert property (!rstn |-> pins == PINS_AT_RESET && mux_pin_out == '0)
    else $error("pins not at reset levels");
  AST_BOOT: assert property (disable iff (!rstn)
    $rose(clock_gen_enable) && !cpu_reset_n |=> s_boot)
    else $error("boot did not follow clock start");
  AST_SOFT: assert property (disable iff (!rstn) cpu_active && cpu_soft_reset |=> s_soft)
    else $error("soft reset sequence wrong");
  AST_MUX: assert property (disable iff (!rstn)
    $past(clock_gen_enable || system_clock_bypass) |-> mux_pin_out ==
    (($past(external_bus_pin_select) & $past(mux_src_b)) |
     (~$past(external_bus_pin_select) & $past(mux_src_a))))
    else $error("muxed pin not from selected source");
  AST_RTC_SET: assert property (!rtc_por_n |-> rtc_power_loss_flag)
    else $error("power loss flag not set by rtc por");
  AST_RTC_HOLD: assert property (disable iff (!rtc_por_n) $past(rtc_por_n) |->
    rtc_power_loss_flag == ($past(rtc_power_loss_flag) && !$past(rtc_loss_clear)))
    else $error("power loss flag changed without cause");
  AST_WAKE_MIN: assert property (disable iff (!rstn) wake_event |-> !cpu_active [*3])
    else $error("wake too fast");
  AST_WAKE_MAX: assert property (disable iff (!rstn) wake_event |-> ##[1:40] cpu_active)
    else $error("wake never completed");
  AST_BYPASS: assert property (disable iff (!rstn)
    system_clock_bypass |-> !clock_gen_enable && !cpu_active)
    else $error("generator on during deepest idle");
endmodule : riw_ctrl_chk

bind riw_ctrl riw_ctrl_chk #(.N_MUX(N_MUX)) i_riw_ctrl_chk (.clk_sys, .rstn, .rtc_por_n,
  .rtc_loss_clear, .cpu_soft_reset, .external_bus_pin_select, .mux_src_a, .mux_src_b, .pins,
  .mux_pin_out, .clock_gen_enable, .system_clock_bypass, .boot_start, .cpu_active,
  .cpu_reset_n, .wake_event, .rtc_power_loss_flag);
`default_nettype wire

// file: testbench/riw_src_model.sv
// behavioural reset, clock tick and interrupt sources facing the controller
`timescale 1ns/1ps
`default_nettype none
module riw_src_model #(
  parameter int REF_DIV = 5,
  parameter int RTC_DIV = 9
) (
  input wire logic clk_sys,
  input wire logic rst_req,
  input wire logic [3:0] irq_go,
  output logic rstn,
  output logic ref_clk_tick,
  output logic rtc_clk_tick,
  output logic [3:0] irq_line
);
  int rc = 8;
  int tr = 0;
  int tc = 0;
  int hold [4] = '{default: 0};
  initial begin
    rstn = 1'b1;
    {ref_clk_tick, rtc_clk_tick, irq_line} = '0;
    #1;
    rstn = 1'b0;
  end
  always @(posedge clk_sys) begin
    // reset held well past the three-cycle minimum
    rc <= rst_req ? 8 : (rc > 0 ? rc - 1 : 0);
    rstn <= (rc == 0) && !rst_req;
    tr <= (tr + 1) % REF_DIV;
    tc <= (tc + 1) % RTC_DIV;
    ref_clk_tick <= (tr == 0);
    rtc_clk_tick <= (tc == 0);
    for (int i = 0; i < 4; i++) begin
      hold[i] <= irq_go[i] ? 4 : (hold[i] > 0 ? hold[i] - 1 : 0);
      irq_line[i] <= hold[i] > 0 || irq_go[i];
    end
  end
endmodule : riw_src_model
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench of the reset and idle wake-up controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import riw_pkg::*;
  localparam int REF_DIV = 5;
  localparam int RTC_DIV = 9;
  logic clk_sys = 1'b0;
  logic rstn, rst_req, rtc_por_n = 1'b1, rtc_loss_clear, cpu_soft_reset, idle_enter;
  logic idle_deep_sel;
  logic clock_source_select, ref_clk_tick, rtc_clk_tick, flag_request, clock_gen_enable;
  logic system_clock_bypass, clk_src_ref, boot_start, cpu_active, cpu_reset_n, wake_event;
  logic rtc_power_loss_flag;
  logic [3:0] irq_go, irq_line;
  logic [7:0] periph_reset_req, periph_int, periph_int_enable, periph_reset_n, int_pending;
  logic [5:0] sel, src_a, src_b, mux_pin_out;
  riw_pin_req_t pin_req;
  riw_pins_t pins;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  logic [40:0] q[$];

  always #10 clk_sys = ~clk_sys;

  riw_src_model #(.REF_DIV(REF_DIV), .RTC_DIV(RTC_DIV)) i_riw_src_model (.clk_sys, .rst_req,
    .irq_go, .rstn, .ref_clk_tick, .rtc_clk_tick, .irq_line);
  riw_ctrl i_riw_ctrl (.clk_sys, .rstn, .rtc_por_n, .rtc_loss_clear, .cpu_soft_reset,
    .periph_reset_req, .idle_enter, .idle_deep_sel, .clock_source_select, .ref_clk_tick,
    .rtc_clk_tick, .wake_input_pin(irq_line[0]), .external_interrupt_pin(irq_line[2:1]),
    .rtc_interrupt(irq_line[3]), .periph_int, .periph_int_enable, .flag_request, .pin_req,
    .external_bus_pin_select(sel), .mux_src_a(src_a), .mux_src_b(src_b), .pins,
    .mux_pin_out, .clock_gen_enable, .system_clock_bypass, .clk_src_ref, .boot_start,
    .cpu_active, .cpu_reset_n, .periph_reset_n, .int_pending, .wake_event,
    .rtc_power_loss_flag);

  // ==========
  // helpers
  task chk(string what, logic [63:0] seen, logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task tick(int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick
  task wait_act(output int k);
    k = 0;
    do begin
      @(posedge clk_sys);
      #1;
      k++;
    end while (cpu_active !== 1'b1 && k < 100);
  endtask : wait_act
  task boot_check;
    @(posedge rstn);
    wait_act(n);
    chk("boot_len", n, 5);
  endtask : boot_check
  task enter_idle;
    @(posedge clk_sys) idle_enter <= 1'b1;
    @(posedge clk_sys) idle_enter <= 1'b0;
    tick(3);
    chk("idle", cpu_active, 0);
  endtask : enter_idle
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ==========
  // tests
  initial begin
    void'($urandom(32'h8f6e99be));
    {rst_req, rtc_loss_clear, cpu_soft_reset, idle_enter, idle_deep_sel} = '0;
    // a real falling edge, seen once every process waits on it
    rtc_por_n <= 1'b0;
    {clock_source_select, flag_request, irq_go, periph_reset_req} = '0;
    {periph_int, periph_int_enable, sel, src_a, src_b} = '0;
    pin_req = '0;
    tick(4);
    chk("pins", pins, PINS_AT_RESET);
    chk("mux", mux_pin_out, 0);
    chk("cpu_reset_n", cpu_reset_n, 0);
    chk("rtc_flag", rtc_power_loss_flag, 1);
    @(posedge clk_sys) rtc_por_n <= 1'b1;
    boot_check();
    $display("test boot done");
    repeat (30) begin
      @(posedge clk_sys);
      sel <= 6'($urandom);
      src_a <= 6'($urandom);
      src_b <= 6'($urandom);
      flag_request <= 1'($urandom);
      pin_req <= riw_pin_req_t'(34'({$urandom, $urandom}));
      #1;
      if (q.size() > 0) chk("pins_mux", {pins, mux_pin_out}, q.pop_front());
      q.push_back({pin_req[33:26], flag_request, pin_req[25:0], (sel & src_b) | (~sel & src_a)});
    end
    $display("test pin mux done");
    for (int s = 0; s < 4; s++) begin
      enter_idle();
      if (s == 3) begin
        @(posedge clk_sys) periph_int <= 8'h01;
        tick(8);
        chk("masked", cpu_active, 0);
        @(posedge clk_sys) periph_int_enable <= 8'h01;
      end else begin
        @(posedge clk_sys) irq_go <= 4'h2 << s;
        @(posedge clk_sys) irq_go <= '0;
      end
      wait_act(n);
      chk("light_wake", n >= 3 && n < 40, 1);
      chk("int_pending", int_pending, {7'h0, s == 3});
      @(posedge clk_sys) periph_int <= '0;
      tick(8);
    end
    $display("test light idle done");
    @(posedge clk_sys) idle_deep_sel <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      @(posedge clk_sys) clock_source_select <= c[0];
      tick(4);
      enter_idle();
      chk("deep", {system_clock_bypass, clock_gen_enable, clk_src_ref}, {2'b10, c[0]});
      @(posedge clk_sys) periph_int <= 8'h01;
      tick(8);
      chk("deep_periph", cpu_active, 0);
      @(posedge clk_sys);
      periph_int <= '0;
      irq_go <= 4'h1;
      @(posedge clk_sys) irq_go <= '0;
      wait_act(n);
      chk("deep_wake", n >= (c ? REF_DIV : RTC_DIV) && n < 40, 1);
      tick(8);
    end
    @(posedge clk_sys) idle_deep_sel <= 1'b0;
    $display("test deep idle done");
    @(posedge clk_sys);
    periph_reset_req <= 8'($urandom);
    cpu_soft_reset <= 1'b1;
    @(posedge clk_sys) cpu_soft_reset <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      #1;
      chk("soft_len", cpu_reset_n, k == 3);
      @(posedge clk_sys);
    end
    #1;
    chk("periph_rst", periph_reset_n, 8'(~periph_reset_req));
    wait_act(n);
    chk("soft_boot", n, 1);
    $display("test soft reset done");
    @(posedge clk_sys) rtc_loss_clear <= 1'b1;
    @(posedge clk_sys) rtc_loss_clear <= 1'b0;
    tick(1);
    chk("rtc_clear", rtc_power_loss_flag, 0);
    @(posedge clk_sys) rst_req <= 1'b1;
    @(posedge clk_sys) rst_req <= 1'b0;
    boot_check();
    chk("rtc_keep", rtc_power_loss_flag, 0);
    @(posedge clk_sys) rtc_por_n <= 1'b0;
    tick(2);
    chk("rtc_por", rtc_power_loss_flag, 1);
    @(posedge clk_sys) rtc_por_n <= 1'b1;
    tick(2);
    $display("test rtc flag done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
